//--- verilog/supply_status_config_regs.sv
// status, configuration and setpoint register bank of the supply
//
// How it works
// - status bit 1 follows output voltage good
// - status bit 5 set once initialization ends
// - status bit 6 flags storage access failure
// - status bit 7 is backup mode
// - parallel role bit unsupported, reads 0
// - unsupported status flags read 0
// - reserved bits read 0, not writable
// - control source select unsupported, reads 0
// - power on preset sets on/off at start
// - battery self test enable, default 1
// - forced start shutdown enable, default 0
// - buffering timer enable, default 0
// - charger status flags buffering timeout
`timescale 1ns/1ps
`include "supply_cfg.svh"
module supply_status_config_regs #(
	parameter longint unsigned MINUTE_CYCLES =
		`MINUTE_S * 64'd1000000000 / `CLK_PERIOD_NS
) (
	input  wire logic                       ref_clk,
	input  wire logic                       resetn,
	input  wire logic                       reg_req,
	input  wire logic                       reg_write,
	input  wire logic [15:0]                reg_addr,
	input  wire logic [15:0]                reg_wdata,
	output logic      [15:0]                reg_rdata,
	output logic                            reg_ack,
	output logic                            reg_error,
	input  wire supply_pkg::telemetry_type  telemetry,
	input  wire logic                       dc_good_pin,
	input  wire logic                       init_complete_pin,
	input  wire logic                       nvm_error_pin,
	input  wire logic                       backup_mode_pin,
	input  wire logic                       prev_on_pin,
	output supply_pkg::control_type         control
);
	import supply_pkg::*;

	if (MINUTE_CYCLES < 1 || MINUTE_CYCLES > 64'h1ffffffff) begin : g_check
		$error("minute count must fit 33 bits");
	end

	localparam int SETPOINTS = 15;
	localparam logic [32:0] MINUTE_LAST = 33'(MINUTE_CYCLES - 1);
	localparam logic [SETPOINTS*16-1:0] SETPOINT_INIT = {
		`TIME_DEF, `AOH_DEF, `AOL_DEF, `AFH_DEF, `AFL_DEF,
		`FUVP_DEF, `UVP_DEF, `TIME_DEF, `TIME_DEF, `TIME_DEF,
		`ITAPER_DEF, `VFLOAT_DEF, `VBST_DEF, `ICHG_DEF, `VOUT_DEF
	};

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [4:0] pin_raw;
	logic [4:0] sync_a;
	logic [4:0] sync_b;
	assign pin_raw = {prev_on_pin, backup_mode_pin, nvm_error_pin,
		init_complete_pin, dc_good_pin};

	for (genvar i = 0; i < 5; i++) begin : g_sync
		always_ff @(posedge ref_clk or negedge resetn) begin
			if (!resetn) begin
				sync_a[i] <= 1'b0;
				sync_b[i] <= 1'b0;
			end else begin
				sync_a[i] <= pin_raw[i];
				sync_b[i] <= sync_a[i];
			end
		end
	end

	logic dc_good_s;
	logic init_complete_s;
	logic nvm_error_s;
	logic backup_s;
	logic prev_on_s;
	assign dc_good_s       = sync_b[0];
	assign init_complete_s = sync_b[1];
	assign nvm_error_s     = sync_b[2];
	assign backup_s        = sync_b[3];
	assign prev_on_s       = sync_b[4];

	// ----------------------------------------------------------------
	// start-up sequencing
	// ----------------------------------------------------------------
	// two settle states let the synchronisers fill before the
	// previous on/off value is trusted
	init_state_type state;
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state <= settle_a;
		end else begin
			unique case (state)
				settle_a: state <= settle_b;
				settle_b: state <= apply;
				apply:    state <= running;
				running:  state <= running;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// status word
	// ----------------------------------------------------------------
	status_low_type status;
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			status <= '0;
		end else begin
			status                         <= '0;
			status.secondary_output_good   <= dc_good_s;
			status.init_done               <= (state == running) &&
				init_complete_s;
			status.nvm_access_error        <= nvm_error_s;
			status.operating_mode_flag     <= backup_s;
		end
	end

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	logic [15:0] setpoint [SETPOINTS];
	logic [SETPOINTS*16-1:0] store_contents;
	for (genvar i = 0; i < SETPOINTS; i++) begin : g_view
		assign setpoint[i] = store_contents[i*16 +: 16];
	end

	function automatic logic [4:0] sp_decode(input logic [15:0] a);
		logic [4:0] r;
		r = 5'h00;
		case (a)
			`OFF_OUTPUT_VOLTAGE_SETPOINT:    r = 5'h10;
			`OFF_ICHG_SET:    r = 5'h11;
			`OFF_VBST_SET:    r = 5'h12;
			`OFF_VFLOAT_SET:  r = 5'h13;
			`OFF_ITAPER_SET:  r = 5'h14;
			`OFF_CC_LIMIT:    r = 5'h15;
			`OFF_CV_LIMIT:    r = 5'h16;
			`OFF_FLOAT_LIMIT: r = 5'h17;
			`OFF_UVP_SET:     r = 5'h18;
			`OFF_FUVP_SET:    r = 5'h19;
			`OFF_AC_FAIL_LO:  r = 5'h1a;
			`OFF_AC_FAIL_HI:  r = 5'h1b;
			`OFF_AC_GOOD_LO:  r = 5'h1c;
			`OFF_AC_GOOD_HI:  r = 5'h1d;
			`OFF_BUFFER_TIME: r = 5'h1e;
			default:          r = 5'h00;
		endcase
		return r;
	endfunction

	// float voltage is bounded above by the boost voltage in force
	function automatic logic in_range(input logic [3:0] idx,
		input logic [15:0] v, input logic [15:0] vbst);
		logic ok;
		ok = 1'b0;
		case (idx)
			4'h0: ok = v >= `VOUT_MIN && v <= `VOUT_MAX;
			4'h1: ok = v >= `ICHG_MIN && v <= `ICHG_MAX;
			4'h2: ok = v >= `VBST_MIN && v <= `VBST_MAX;
			4'h3: ok = v >= `VFLOAT_MIN && v <= vbst;
			4'h4: ok = v >= `ITAPER_MIN && v <= `ITAPER_MAX;
			4'h8: ok = v >= `UVP_MIN && v <= `UVP_MAX;
			4'h9: ok = v >= `FUVP_MIN && v <= `FUVP_MAX;
			4'ha: ok = v >= `AFL_MIN && v <= `AFL_MAX;
			4'hb: ok = v >= `AFH_MIN && v <= `AFH_MAX;
			4'hc: ok = v >= `AOL_MIN && v <= `AOL_MAX;
			4'hd: ok = v >= `AOH_MIN && v <= `AOH_MAX;
			default: ok = v >= `TIME_MIN && v <= `TIME_MAX;
		endcase
		return ok;
	endfunction

	logic [4:0] sp_hit;
	logic       write_req;
	logic       sp_ok;
	logic       sp_write;
	assign sp_hit    = sp_decode(reg_addr);
	assign write_req = reg_req && reg_write;
	assign sp_ok     = in_range(sp_hit[3:0], reg_wdata, setpoint[2]);
	assign sp_write  = write_req && sp_hit[4] && sp_ok;

	setpoint_store #(
		.WIDTH (16),
		.DEPTH (SETPOINTS),
		.INIT  (SETPOINT_INIT)
	) u_store (
		.ref_clk     (ref_clk),
		.resetn      (resetn),
		.write_en    (sp_write),
		.write_index (sp_hit[3:0]),
		.write_data  (reg_wdata),
		.contents    (store_contents)
	);

	// ----------------------------------------------------------------
	// on/off command and power-on preset
	// ----------------------------------------------------------------
	logic on_off;
	logic [1:0] preset;
	logic on_ok;
	assign on_ok = reg_wdata[15:1] == 15'h0000;
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			on_off <= 1'(`ON_OFF_RESET);
		end else if (state == apply) begin
			unique case (preset)
				2'b00: on_off <= 1'b0;
				2'b01: on_off <= 1'b1;
				2'b10: on_off <= prev_on_s;
				2'b11: on_off <= on_off;
			endcase
		end else if (write_req && reg_addr == `OFF_ON_OFF && on_ok) begin
			on_off <= reg_wdata[0];
		end
	end

	// only the preset field is stored; control source stays at 0
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			preset <= `PRESET_RESET;
		end else if (write_req && reg_addr == `OFF_GLOBAL &&
			reg_wdata[`GLOBAL_PRESET_LSB +: 2] != 2'b11) begin
			preset <= reg_wdata[`GLOBAL_PRESET_LSB +: 2];
		end
	end

	// ----------------------------------------------------------------
	// backup settings
	// ----------------------------------------------------------------
	logic self_test_en;
	logic forced_off_en;
	logic buff_timer_en;
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			self_test_en  <= `SELF_TEST_RESET;
			forced_off_en <= `FORCED_OFF_RESET;
			buff_timer_en <= `BUFF_TIMER_RESET;
		end else if (write_req && reg_addr == `OFF_BACKUP) begin
			self_test_en  <= reg_wdata[0];
			forced_off_en <= reg_wdata[1];
			buff_timer_en <= reg_wdata[2];
		end
	end

	// ----------------------------------------------------------------
	// buffering timer
	// ----------------------------------------------------------------
	// counts whole minutes of backup operation; leaving backup mode
	// restarts it, so the flag describes the current outage only
	logic [32:0] tick_count;
	logic [15:0] minutes;
	logic        timing;
	logic        buff_timeout;
	assign timing = buff_timer_en && backup_s;
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tick_count <= '0;
			minutes    <= '0;
		end else if (!timing) begin
			tick_count <= '0;
			minutes    <= '0;
		end else if (tick_count == MINUTE_LAST) begin
			tick_count <= '0;
			if (minutes != 16'hffff) begin
				minutes <= minutes + 16'h0001;
			end
		end else begin
			tick_count <= tick_count + 33'h000000001;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			buff_timeout <= 1'b0;
		end else if (timing && minutes >= setpoint[14]) begin
			buff_timeout <= 1'b1;
		end else if (!backup_s) begin
			buff_timeout <= 1'b0;
		end
	end

	assign control = '{on_off, self_test_en, forced_off_en,
		buff_timer_en, buff_timeout};

	// ----------------------------------------------------------------
	// read mux and answer
	// ----------------------------------------------------------------
	logic [15:0] next_rdata;
	logic        next_error;
	always_comb begin
		next_rdata = 16'h0000;
		next_error = 1'b0;
		if (sp_hit[4]) begin
			next_rdata = setpoint[sp_hit[3:0]];
			next_error = reg_write && !sp_ok;
		end else begin
			case (reg_addr)
				`OFF_ON_OFF: begin
					next_rdata = {15'h0000, on_off};
					next_error = reg_write && !on_ok;
				end
				`OFF_GLOBAL: next_rdata = {13'h0000, preset, 1'b0};
				`OFF_BACKUP: next_rdata = {13'h0000, buff_timer_en,
					forced_off_en, self_test_en};
				`OFF_STATUS: next_rdata = {8'h00, status};
				`OFF_CHG_STATUS:
					next_rdata = 16'(buff_timeout) << `BUFF_TIMEOUT_BIT;
				`OFF_VIN_READ:   next_rdata = telemetry.vin;
				`OFF_VOUT_READ:  next_rdata = telemetry.vout;
				`OFF_IOUT_READ:  next_rdata = telemetry.iout;
				`OFF_TEMP_READ:  next_rdata = telemetry.temp;
				`OFF_VBAT_READ:  next_rdata = telemetry.vbat;
				`OFF_IBAT_READ:  next_rdata = telemetry.ibat;
				`OFF_BTEMP_READ: next_rdata = telemetry.bat_temp;
				default:         next_error = 1'b1;
			endcase
			if (reg_write && (reg_addr == `OFF_STATUS ||
				reg_addr == `OFF_CHG_STATUS ||
				reg_addr == `OFF_VIN_READ || reg_addr == `OFF_VOUT_READ ||
				reg_addr == `OFF_IOUT_READ || reg_addr == `OFF_TEMP_READ ||
				reg_addr == `OFF_VBAT_READ || reg_addr == `OFF_IBAT_READ ||
				reg_addr == `OFF_BTEMP_READ)) begin
				next_error = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			reg_ack   <= 1'b0;
			reg_rdata <= 16'h0000;
			reg_error <= 1'b0;
		end else begin
			reg_ack   <= reg_req;
			reg_rdata <= (reg_req && !reg_write) ? next_rdata : 16'h0000;
			reg_error <= reg_req && next_error;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	sequence global_read;
		reg_req && !reg_write && reg_addr == `OFF_GLOBAL;
	endsequence

	sequence vout_bad_write;
		reg_req && reg_write && reg_addr == `OFF_OUTPUT_VOLTAGE_SETPOINT &&
			(reg_wdata < `VOUT_MIN || reg_wdata > `VOUT_MAX);
	endsequence

	AST_DC_GOOD: assert property (dc_good_pin [*3] |=>
		status.secondary_output_good)
		else $error("output good bit does not follow pin");
	AST_INIT_PENDING: assert property ((state != running) |=>
		!status.init_done)
		else $error("init done shown during initialization");
	AST_NVM_ERROR: assert property ($fell(nvm_error_s) |=>
		!status.nvm_access_error)
		else $error("storage error flag stuck");
	AST_MODE: assert property (!backup_mode_pin [*3] |=>
		!status.operating_mode_flag)
		else $error("backup mode shown while charging");
	AST_UNSUPPORTED: assert property (!status.parallel_role &&
		!status.primary_pfc_good && !status.oring_switch_forced_off &&
		!status.dummy_load_active)
		else $error("unsupported status bit set");
	AST_RESERVED: assert property (global_read |=> reg_ack &&
		reg_rdata[15:3] == 13'h0000 && !reg_rdata[0])
		else $error("reserved or unsupported config bit reads 1");
	AST_PRESET_ON: assert property (state == apply &&
		preset == 2'b01 |=> control.on_off ##1 state == running)
		else $error("on preset not applied at start");
	AST_RANGE: assert property (vout_bad_write |=>
		$stable(setpoint[0]) && reg_error)
		else $error("out of range setpoint was applied");
	AST_TIMEOUT: assert property ($rose(buff_timeout) |->
		$past(buff_timer_en) && $past(backup_s))
		else $error("buffering timeout without enabled timer");
	AST_BACKUP_READ: assert property (reg_req && !reg_write &&
		reg_addr == `OFF_BACKUP |=> reg_rdata[2:0] ==
		{control.buffering_timer_enable,
		control.forced_start_shutdown_enable,
		control.battery_self_test_enable})
		else $error("backup settings read back wrong");

endmodule

//--- verilog/supply_cfg.svh
// offsets, field positions, reset values and timing counts of the register bank
`ifndef SUPPLY_CFG_SVH
`define SUPPLY_CFG_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFF_ON_OFF        16'h0000
`define OFF_OUTPUT_VOLTAGE_SETPOINT      16'h0020
`define OFF_VIN_READ      16'h0050
`define OFF_VOUT_READ     16'h0060
`define OFF_IOUT_READ     16'h0061
`define OFF_TEMP_READ     16'h0062
`define OFF_ICHG_SET      16'h00b0
`define OFF_VBST_SET      16'h00b1
`define OFF_VFLOAT_SET    16'h00b2
`define OFF_ITAPER_SET    16'h00b3
`define OFF_CC_LIMIT      16'h00b5
`define OFF_CV_LIMIT      16'h00b6
`define OFF_FLOAT_LIMIT   16'h00b7
`define OFF_CHG_STATUS    16'h00b8
`define OFF_STATUS        16'h00c1
`define OFF_GLOBAL        16'h00c2
`define OFF_UVP_SET       16'h00d0
`define OFF_FUVP_SET      16'h00d1
`define OFF_BACKUP        16'h00d2
`define OFF_VBAT_READ     16'h00d3
`define OFF_IBAT_READ     16'h00d4
`define OFF_BTEMP_READ    16'h00d5
`define OFF_AC_FAIL_LO    16'h00e0
`define OFF_AC_FAIL_HI    16'h00e1
`define OFF_AC_GOOD_LO    16'h00e2
`define OFF_AC_GOOD_HI    16'h00e3
`define OFF_BUFFER_TIME   16'h00e4

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define GLOBAL_PRESET_LSB 1
`define BUFF_TIMEOUT_BIT  12
`define ON_OFF_RESET      16'h0001
`define PRESET_RESET      2'h1
`define SELF_TEST_RESET   1'h1
`define FORCED_OFF_RESET  1'h0
`define BUFF_TIMER_RESET  1'h0

// ----------------------------------------------------------------
// setpoint ranges and defaults (volts x100, amps x100, mains x10)
// ----------------------------------------------------------------
`define VOUT_MIN          16'h03e8
`define VOUT_MAX          16'h0578
`define VOUT_DEF          16'h04b0
`define ICHG_MIN          16'h0190
`define ICHG_MAX          16'h07d0
`define ICHG_DEF          16'h07d0
`define VBST_MIN          16'h0384
`define VBST_MAX          16'h05dc
`define VBST_DEF          16'h05a0
`define VFLOAT_MIN        16'h0384
`define VFLOAT_DEF        16'h0564
`define ITAPER_MIN        16'h0028
`define ITAPER_MAX        16'h00c8
`define ITAPER_DEF        16'h00c8
`define TIME_MIN          16'h003c
`define TIME_MAX          16'hfd20
`define TIME_DEF          16'h0258
`define UVP_MIN           16'h03c0
`define UVP_MAX           16'h04b0
`define UVP_DEF           16'h0414
`define FUVP_MIN          16'h0348
`define FUVP_MAX          16'h04b0
`define FUVP_DEF          16'h0348
`define AFL_MIN           16'h0334
`define AFL_MAX           16'h04b0
`define AFL_DEF           16'h0334
`define AFH_MIN           16'h0528
`define AFH_MAX           16'h071c
`define AFH_DEF           16'h06b4
`define AOL_MIN           16'h0366
`define AOL_MAX           16'h04e2
`define AOL_DEF           16'h0366
`define AOH_MIN           16'h055a
`define AOH_MAX           16'h074e
`define AOH_DEF           16'h0722

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS     10
`define MINUTE_S          60

`endif

//--- verilog/supply_pkg.sv
// types shared by the supply register bank
package supply_pkg;

	typedef struct packed {
		logic [15:0] vin;
		logic [15:0] vout;
		logic [15:0] iout;
		logic [15:0] temp;
		logic [15:0] ibat;
		logic [15:0] bat_temp;
		logic [15:0] vbat;
	} telemetry_type;

	typedef struct packed {
		logic operating_mode_flag;
		logic nvm_access_error;
		logic init_done;
		logic dummy_load_active;
		logic oring_switch_forced_off;
		logic primary_pfc_good;
		logic secondary_output_good;
		logic parallel_role;
	} status_low_type;

	typedef struct packed {
		logic on_off;
		logic battery_self_test_enable;
		logic forced_start_shutdown_enable;
		logic buffering_timer_enable;
		logic buffering_timeout_flag;
	} control_type;

	typedef enum logic [1:0] {
		settle_a = 2'b00,
		settle_b = 2'b01,
		apply    = 2'b10,
		running  = 2'b11
	} init_state_type;

endpackage

//--- verilog/setpoint_store.sv
// register store for the writable setpoints
`timescale 1ns/1ps
module setpoint_store #(
	parameter int                     WIDTH = 16,
	parameter int                     DEPTH = 15,
	parameter logic [DEPTH*WIDTH-1:0] INIT  = '0
) (
	input  wire logic                     ref_clk,
	input  wire logic                     resetn,
	input  wire logic                     write_en,
	input  wire logic [3:0]               write_index,
	input  wire logic [WIDTH-1:0]         write_data,
	output logic      [DEPTH*WIDTH-1:0]   contents
);

	if (DEPTH < 1 || DEPTH > 16 || WIDTH < 1) begin : g_check
		$error("setpoint_store: depth must be 1..16");
	end

	// ----------------------------------------------------------------
	// one word per entry, all readable in parallel
	// ----------------------------------------------------------------
	for (genvar i = 0; i < DEPTH; i++) begin : g_entry
		always_ff @(posedge ref_clk or negedge resetn) begin
			if (!resetn) begin
				contents[i*WIDTH +: WIDTH] <= INIT[i*WIDTH +: WIDTH];
			end else if (write_en && write_index == 4'(i)) begin
				contents[i*WIDTH +: WIDTH] <= write_data;
			end
		end
	end

endmodule

//--- bench/host_model.sv
// host side model that issues accesses on the bank's request port
`timescale 1ns/1ps
module host_model (
	input  wire logic        ref_clk,
	output logic             reg_req,
	output logic             reg_write,
	output logic [15:0]      reg_addr,
	output logic [15:0]      reg_wdata,
	input  wire logic [15:0] reg_rdata,
	input  wire logic        reg_ack,
	input  wire logic        reg_error
);
	// ------------------------------------------------------------
	// idle request port
	// ------------------------------------------------------------
	initial begin
		reg_req = 1'b0;
		reg_write = 1'b0;
		reg_addr = 16'h0000;
		reg_wdata = 16'h0000;
	end

	// ------------------------------------------------------------
	// one access: request held over one rising edge
	// ------------------------------------------------------------
	// answer is sampled at the next falling edge, while ack stands
	task automatic access(input logic wr, input logic [15:0] addr,
		input logic [15:0] data, output logic [15:0] rd,
		output logic err, output logic ack);
		@(negedge ref_clk);
		reg_req = 1'b1;
		reg_write = wr;
		reg_addr = addr;
		reg_wdata = data;
		@(negedge ref_clk);
		rd = reg_rdata;
		err = reg_error;
		ack = reg_ack;
		reg_req = 1'b0;
		// released data must not look like a live value
		reg_wdata = ~data;
	endtask
endmodule

//--- bench/test_supply_status_config_regs.sv
// self-checking testbench of the supply register bank
`timescale 1ns/1ps
`include "supply_cfg.svh"
module test_supply_status_config_regs;
	import supply_pkg::*;
	logic          ref_clk = 1'b0;
	logic          resetn = 1'b0;
	logic          reg_req;
	logic          reg_write;
	logic [15:0]   reg_addr;
	logic [15:0]   reg_wdata;
	logic [15:0]   reg_rdata;
	logic          reg_ack;
	logic          reg_error;
	telemetry_type telemetry;
	logic          dc_good_pin = 1'b1;
	logic          init_complete_pin = 1'b1;
	logic          nvm_error_pin = 1'b0;
	logic          backup_mode_pin = 1'b0;
	logic          prev_on_pin = 1'b0;
	control_type   control;
	int            n_errors = 0;
	int            total_checks = 0;

	// ------------------------------------------------------------
	// clock, design and host
	// ------------------------------------------------------------
	always #5 ref_clk = ~ref_clk;

	// short minute keeps the buffering run to a few hundred cycles
	supply_status_config_regs #(.MINUTE_CYCLES(10)) dut (
		.ref_clk(ref_clk), .resetn(resetn), .reg_req(reg_req),
		.reg_write(reg_write), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_ack(reg_ack), .reg_error(reg_error),
		.telemetry(telemetry), .dc_good_pin(dc_good_pin),
		.init_complete_pin(init_complete_pin),
		.nvm_error_pin(nvm_error_pin),
		.backup_mode_pin(backup_mode_pin),
		.prev_on_pin(prev_on_pin), .control(control)
	);

	host_model host (
		.ref_clk(ref_clk), .reg_req(reg_req), .reg_write(reg_write),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_ack(reg_ack),
		.reg_error(reg_error)
	);

	// ------------------------------------------------------------
	// comparison, access and closing tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] want);
		total_checks++;
		if (seen !== want) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, want,
				seen);
		end
	endtask

	// for a read d is the expected data; writes return zero data
	task automatic xfer(input logic w, input logic [15:0] a,
		input logic [15:0] d, input logic e);
		logic [15:0] r;
		logic        er;
		logic        ak;
		host.access(w, a, w ? d : 16'h0000, r, er, ak);
		check("reg_ack", {15'h0000, ak}, 16'h0001);
		check("reg_error", {15'h0000, er}, {15'h0000, e});
		check("reg_rdata", r, w ? 16'h0000 : d);
	endtask

	task automatic bit_chk(input string what, input logic s,
		input logic x);
		check(what, {15'h0000, s}, {15'h0000, x});
	endtask

	task automatic wrap_up;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// watchdog
	// ------------------------------------------------------------
	initial begin
		repeat (5000) @(posedge ref_clk);
		n_errors++;
		wrap_up();
	end

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		telemetry = '0;
		telemetry.vin = 16'h0abc;
		telemetry.vbat = 16'h0555;
		repeat (12) @(negedge ref_clk);
		resetn = 1'b1;
		repeat (6) @(negedge ref_clk);
		bit_chk("on_off", control.on_off, 1'b1);
		bit_chk("self_test", control.battery_self_test_enable, 1'b1);
		xfer(0, `OFF_BACKUP, 16'h0001, 0);
		xfer(0, `OFF_GLOBAL, 16'h0002, 0);
		xfer(0, `OFF_STATUS, 16'h0022, 0);
		xfer(0, `OFF_VIN_READ, 16'h0abc, 0);
		xfer(0, `OFF_VBAT_READ, 16'h0555, 0);
		// status flags follow their pins, unsupported bits stay low
		dc_good_pin = 1'b0;
		nvm_error_pin = 1'b1;
		backup_mode_pin = 1'b1;
		repeat (4) @(negedge ref_clk);
		xfer(0, `OFF_STATUS, 16'h00e0, 0);
		init_complete_pin = 1'b0;
		repeat (4) @(negedge ref_clk);
		xfer(0, `OFF_STATUS, 16'h00c0, 0);
		dc_good_pin = 1'b1;
		nvm_error_pin = 1'b0;
		backup_mode_pin = 1'b0;
		init_complete_pin = 1'b1;
		// control source bit never sticks; reserved preset is dropped
		xfer(1, `OFF_GLOBAL, 16'h0001, 0);
		xfer(0, `OFF_GLOBAL, 16'h0000, 0);
		xfer(1, `OFF_GLOBAL, 16'h0006, 0);
		xfer(0, `OFF_GLOBAL, 16'h0000, 0);
		xfer(1, `OFF_GLOBAL, 16'h0004, 0);
		xfer(0, `OFF_GLOBAL, 16'h0004, 0);
		// on/off accepts only off and on
		xfer(1, `OFF_ON_OFF, 16'h0000, 0);
		bit_chk("on_off", control.on_off, 1'b0);
		xfer(1, `OFF_ON_OFF, 16'h0002, 1);
		xfer(0, `OFF_ON_OFF, 16'h0000, 0);
		// setpoint bounds, both edges, back to back
		xfer(1, `OFF_OUTPUT_VOLTAGE_SETPOINT, 16'h03e8, 0);
		xfer(0, `OFF_OUTPUT_VOLTAGE_SETPOINT, 16'h03e8, 0);
		xfer(1, `OFF_OUTPUT_VOLTAGE_SETPOINT, 16'h0579, 1);
		xfer(0, `OFF_OUTPUT_VOLTAGE_SETPOINT, 16'h03e8, 0);
		xfer(1, `OFF_OUTPUT_VOLTAGE_SETPOINT, 16'h0578, 0);
		xfer(1, `OFF_OUTPUT_VOLTAGE_SETPOINT, 16'h03e7, 1);
		xfer(0, `OFF_OUTPUT_VOLTAGE_SETPOINT, 16'h0578, 0);
		// float ceiling follows the boost setpoint
		xfer(1, `OFF_VBST_SET, 16'h0500, 0);
		xfer(1, `OFF_VFLOAT_SET, 16'h0501, 1);
		xfer(1, `OFF_VFLOAT_SET, 16'h0500, 0);
		xfer(0, `OFF_VFLOAT_SET, 16'h0500, 0);
		// read-only and unmapped places
		xfer(1, `OFF_VIN_READ, 16'h0001, 1);
		xfer(0, `OFF_VIN_READ, 16'h0abc, 0);
		xfer(0, 16'h0001, 16'h0000, 1);
		// forced start shutdown on, self test off
		xfer(1, `OFF_BACKUP, 16'h0002, 0);
		xfer(0, `OFF_BACKUP, 16'h0002, 0);
		bit_chk("forced_off", control.forced_start_shutdown_enable, 1'b1);
		bit_chk("self_test", control.battery_self_test_enable, 1'b0);
		// buffering: 60 minutes of 10 cycles in backup mode
		xfer(1, `OFF_BUFFER_TIME, `TIME_MIN, 0);
		xfer(1, `OFF_BACKUP, 16'h0005, 0);
		bit_chk("timer_en", control.buffering_timer_enable, 1'b1);
		backup_mode_pin = 1'b1;
		repeat (300) @(negedge ref_clk);
		xfer(0, `OFF_CHG_STATUS, 16'h0000, 0);
		repeat (400) @(negedge ref_clk);
		xfer(0, `OFF_CHG_STATUS, 16'h1000, 0);
		bit_chk("timeout", control.buffering_timeout_flag, 1'b1);
		backup_mode_pin = 1'b0;
		repeat (5) @(negedge ref_clk);
		xfer(0, `OFF_CHG_STATUS, 16'h0000, 0);
		bit_chk("timeout", control.buffering_timeout_flag, 1'b0);
		// reset mid-run: an early off write is overruled by the preset
		resetn = 1'b0;
		@(negedge ref_clk);
		resetn = 1'b1;
		xfer(1, `OFF_ON_OFF, 16'h0000, 0);
		bit_chk("early_off", control.on_off, 1'b0);
		@(negedge ref_clk);
		bit_chk("on_off", control.on_off, 1'b1);
		xfer(0, `OFF_GLOBAL, 16'h0002, 0);
		wrap_up();
	end
endmodule
